// ===== hw/fbus_pkg.sv
// Shared constants and types for the fieldbus address check link
package fbus_pkg;
    // Address limits
    localparam logic [7:0] ADDR_UNSET      = 8'hFF;
    localparam logic [7:0] ADDR_MIN        = 8'h02;
    localparam logic [7:0] ADDR_MAX_TOKEN  = 8'h7D;
    localparam logic [7:0] ADDR_MAX_CAN    = 8'h40;
    localparam logic [7:0] ADDR_MAX_SERIAL = 8'h7D;
    localparam logic [7:0] ADDR_MIN_ETH    = 8'h01;
    localparam logic [7:0] ADDR_MAX_ETH    = 8'hFE;

    typedef enum logic [1:0] {
        NET_TOKEN  = 2'h0,
        NET_CAN    = 2'h1,
        NET_SERIAL = 2'h2,
        NET_ETH    = 2'h3
    } net_t;

    // Controller start-up sequence, Gray along DETACH-CHECK-SYNC-RUN
    typedef enum logic [2:0] {
        ST_DETACH = 3'h0,
        ST_CHECK  = 3'h1,
        ST_SYNC   = 3'h3,
        ST_RUN    = 3'h2,
        ST_HALT   = 3'h6
    } ctl_state_t;

    // Motor run codes and bus fault reactions
    localparam logic [1:0] RUN_STOP    = 2'h0;
    localparam logic [1:0] RUN_FWD     = 2'h1;
    localparam logic [1:0] RUN_REV     = 2'h2;
    localparam logic [1:0] REACT_KEEP  = 2'h0;
    localparam logic [1:0] REACT_STOP  = 2'h1;
    localparam logic [1:0] REACT_FWD   = 2'h2;
    localparam logic [1:0] REACT_REV   = 2'h3;

    // Register offsets
    localparam logic [7:0] REG_ADDR    = 8'h00;
    localparam logic [7:0] REG_CONFIG  = 8'h04;
    localparam logic [7:0] REG_CMD     = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0C;
    localparam logic [7:0] REG_PARAM   = 8'h10;

    // Field positions
    localparam int CFG_CHECK   = 0;
    localparam int CFG_LOCK    = 1;
    localparam int CFG_PROFILE = 2;
    localparam int CFG_RETRO   = 3;
    localparam int CMD_FIX     = 0;
    localparam int CMD_RECHECK = 1;
    localparam int PARAM_REACT = 16;

    // Monitoring words
    localparam int         NUM_MON       = 5;
    localparam int         NUM_SRC       = 8;
    localparam logic [2:0] LEN_FULL      = 3'h5;
    localparam logic [2:0] LEN_REDUCED   = 3'h2;
    localparam logic [14:0] MONSEL_RESET = 15'h4688;
endpackage : fbus_pkg

// ===== hw/fbus_link_if.sv
// Link between the motor controller and its communication interface
`timescale 1ns/1ps
`default_nettype none
interface fbus_link_if;
    logic                  ci_present;
    logic [7:0]            ci_addr;
    fbus_pkg::net_t        ci_net;
    logic                  ci_ack;
    logic                  ci_bus_fault;
    logic [1:0]            ci_cmd;
    logic                  bp_valid;
    logic [31:0]           bp_data;
    logic [7:0]            ctl_addr;
    logic                  ctl_wr;
    logic                  comm_en;
    logic [4:0][15:0]      cyc_word;
    logic [2:0]            cyc_len;

    modport ctl (
        input  ci_present, ci_addr, ci_net, ci_ack, ci_bus_fault, ci_cmd,
        input  bp_valid, bp_data,
        output ctl_addr, ctl_wr, comm_en, cyc_word, cyc_len
    );
    modport ci (
        output ci_present, ci_addr, ci_net, ci_ack, ci_bus_fault, ci_cmd,
        output bp_valid, bp_data,
        input  ctl_addr, ctl_wr, comm_en, cyc_word, cyc_len
    );
endinterface : fbus_link_if
`default_nettype wire

// ===== hw/fbus_addr_range.sv
// Bus address range check per network type
`timescale 1ns/1ps
`default_nettype none
module fbus_addr_range (
    input  wire logic [7:0]     addr,
    input  wire fbus_pkg::net_t net,
    output logic                ok
);
    // Unset code 255 lies outside every range, so it never passes
    always_comb begin
        unique case (net)
            fbus_pkg::NET_TOKEN: begin
                ok = addr >= fbus_pkg::ADDR_MIN
                    && addr <= fbus_pkg::ADDR_MAX_TOKEN;
            end
            fbus_pkg::NET_CAN: begin
                ok = addr >= fbus_pkg::ADDR_MIN
                    && addr <= fbus_pkg::ADDR_MAX_CAN;
            end
            fbus_pkg::NET_SERIAL: begin
                ok = addr >= fbus_pkg::ADDR_MIN
                    && addr <= fbus_pkg::ADDR_MAX_SERIAL;
            end
            fbus_pkg::NET_ETH: begin
                // Identity only, so any host octet short of broadcast
                ok = addr >= fbus_pkg::ADDR_MIN_ETH
                    && addr <= fbus_pkg::ADDR_MAX_ETH;
            end
        endcase
    end
endmodule : fbus_addr_range
`default_nettype wire

// ===== hw/fbus_ci_end.sv
// Communication interface end of the address check link
`timescale 1ns/1ps
`default_nettype none
module fbus_ci_end (
    input  wire logic         SYS_CLK,
    input  wire logic         ARST_N,
    input  wire logic         ATTACHED,
    input  wire logic [1:0]   NET_TYPE,
    input  wire logic [7:0]   NV_ADDR,
    input  wire logic         IGNORE_BP,
    input  wire logic         BP_IN_VALID,
    input  wire logic [31:0]  BP_IN_DATA,
    input  wire logic         BUS_FAULT,
    input  wire logic [1:0]   CMD_RUN,
    fbus_link_if.ci           LINK,
    output logic              NV_WR,
    output logic [7:0]        NV_WDATA,
    output logic              BUS_UP,
    output logic [4:0][15:0]  CYC_WORD,
    output logic [2:0]        CYC_LEN
);
    typedef struct packed {
        logic             att_meta;
        logic             att;
        logic             loaded;
        logic             present;
        fbus_pkg::net_t   net;
        logic [7:0]       addr;
        logic             ack;
        logic             nv_wr;
        logic             bpv;
        logic [31:0]      bpd;
        logic             fault;
        logic [1:0]       cmd;
        logic             up;
        logic [4:0][15:0] cyc;
        logic [2:0]       len;
    } ci_regs_t;

    localparam ci_regs_t CI_RESET = '{
        net: fbus_pkg::NET_TOKEN, addr: fbus_pkg::ADDR_UNSET, default: '0};

    ci_regs_t r;
    ci_regs_t next_r;
    logic     wr_ok;

    fbus_addr_range u_rng (
        .addr (LINK.ctl_addr),
        .net  (r.net),
        .ok   (wr_ok)
    );

    // Straps and stored address are caught on the first clock after reset
    always_comb begin
        next_r          = r;
        next_r.ack      = 1'b0;
        next_r.nv_wr    = 1'b0;
        next_r.att_meta = ATTACHED;
        next_r.att      = r.att_meta;
        next_r.present  = r.att && r.loaded;
        if (!r.loaded) begin
            next_r.loaded = 1'b1;
            next_r.net    = fbus_pkg::net_t'(NET_TYPE);
            next_r.addr   = NV_ADDR;
        end
        // Out-of-range writes are acknowledged but not kept
        if (LINK.ctl_wr) begin
            next_r.ack = 1'b1;
            if (wr_ok) begin
                next_r.addr  = LINK.ctl_addr;
                next_r.nv_wr = 1'b1;
            end
        end
        next_r.bpv   = BP_IN_VALID && !IGNORE_BP;
        next_r.bpd   = BP_IN_DATA;
        next_r.fault = BUS_FAULT;
        next_r.cmd   = CMD_RUN;
        next_r.up    = LINK.comm_en;
        next_r.cyc   = LINK.cyc_word;
        next_r.len   = LINK.cyc_len;
    end

    // State register
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= CI_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign LINK.ci_present   = r.present;
    assign LINK.ci_addr      = r.addr;
    assign LINK.ci_net       = r.net;
    assign LINK.ci_ack       = r.ack;
    assign LINK.ci_bus_fault = r.fault;
    assign LINK.ci_cmd       = r.cmd;
    assign LINK.bp_valid     = r.bpv;
    assign LINK.bp_data      = r.bpd;
    assign NV_WR             = r.nv_wr;
    assign NV_WDATA          = r.addr;
    assign BUS_UP            = r.up;
    assign CYC_WORD          = r.cyc;
    assign CYC_LEN           = r.len;
endmodule : fbus_ci_end
`default_nettype wire

// ===== hw/fbus_ctl_end.sv
// Motor controller end: address agreement, settings and cyclic data
`timescale 1ns/1ps
`default_nettype none
module fbus_ctl_end (
    input  wire logic                SYS_CLK,
    input  wire logic                ARST_N,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [7:0]          PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic [31:0]              PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic [7:0][15:0]    MON_SRC,
    fbus_link_if.ctl                 LINK,
    output logic [1:0]               MOTOR_RUN,
    output logic                     COMM_ACTIVE,
    output logic                     ADDR_FAULT,
    output logic                     LOCK_IND,
    output logic                     ADDR_SAVE,
    output logic [7:0]               SAVED_ADDR
);
    typedef struct packed {
        fbus_pkg::ctl_state_t st;
        logic [7:0]           bus_addr;
        logic                 check;
        logic                 lock;
        logic                 profile2;
        logic                 retrofit;
        logic [14:0]          monsel;
        logic [1:0]           react;
        logic                 addr_fault;
        logic                 no_addr;
        logic                 save;
        logic                 wr;
        logic [7:0]           wr_addr;
        logic                 comm;
        logic                 retry;
        logic [1:0]           motor;
        logic [4:0][15:0]     cyc;
        logic [2:0]           cyc_len;
        logic                 ready;
        logic                 slverr;
        logic [31:0]          rdata;
    } ctl_regs_t;

    localparam ctl_regs_t CTL_RESET = '{
        st:       fbus_pkg::ST_DETACH,
        bus_addr: fbus_pkg::ADDR_UNSET,
        monsel:   fbus_pkg::MONSEL_RESET,
        default:  '0};

    ctl_regs_t        r;
    ctl_regs_t        next_r;
    logic             own_ok;
    logic             ci_ok;
    logic             access;
    logic             commit;
    logic             fix;
    logic [4:0][15:0] mon_word;
    logic [2:0]       mon_len;

    // Validity of both addresses against the attached network type
    fbus_addr_range u_own (
        .addr (r.bus_addr),
        .net  (LINK.ci_net),
        .ok   (own_ok)
    );
    fbus_addr_range u_ci (
        .addr (LINK.ci_addr),
        .net  (LINK.ci_net),
        .ok   (ci_ok)
    );

    // Reduced profile keeps only the leading words
    assign mon_len = r.profile2 ? fbus_pkg::LEN_REDUCED
                                : fbus_pkg::LEN_FULL;

    // Per word source select; retrofit forces the fixed legacy order
    for (genvar i = 0; i < fbus_pkg::NUM_MON; i++) begin : g_mon
        logic [2:0] sel;
        assign sel = r.retrofit ? fbus_pkg::MONSEL_RESET[3*i +: 3]
                                : r.monsel[3*i +: 3];
        assign mon_word[i] = (r.comm && 3'(i) < mon_len)
                           ? MON_SRC[sel] : 16'h0000;
    end

    // APB phases: one wait cycle, write lands on the PREADY edge
    assign access = PSEL && PENABLE && !r.ready;
    assign commit = PSEL && PENABLE && r.ready;
    assign fix    = commit && PWRITE && !r.slverr
                    && PADDR == fbus_pkg::REG_CMD
                    && PWDATA[fbus_pkg::CMD_FIX];

    always_comb begin
        next_r       = r;
        next_r.save  = 1'b0;
        next_r.wr    = 1'b0;
        next_r.ready = access;

        // Start-up agreement; every path ends in RUN or HALT
        unique case (r.st)
            fbus_pkg::ST_DETACH: begin
                if (LINK.ci_present) begin
                    next_r.st = fbus_pkg::ST_CHECK;
                end
            end
            fbus_pkg::ST_CHECK: begin
                next_r.addr_fault = 1'b0;
                next_r.no_addr    = 1'b0;
                if (!own_ok && !ci_ok) begin
                    next_r.no_addr = 1'b1;
                    next_r.st      = fbus_pkg::ST_HALT;
                end else if (!ci_ok) begin
                    next_r.wr      = 1'b1;
                    next_r.wr_addr = r.bus_addr;
                    next_r.st      = fbus_pkg::ST_SYNC;
                end else if (!own_ok) begin
                    next_r.bus_addr = LINK.ci_addr;
                    next_r.save     = 1'b1;
                    next_r.st       = fbus_pkg::ST_RUN;
                end else if (r.bus_addr == LINK.ci_addr) begin
                    next_r.st = fbus_pkg::ST_RUN;
                end else if (!r.check) begin
                    next_r.wr      = 1'b1;
                    next_r.wr_addr = r.bus_addr;
                    next_r.st      = fbus_pkg::ST_SYNC;
                end else begin
                    next_r.addr_fault = 1'b1;
                    next_r.st         = fbus_pkg::ST_HALT;
                end
            end
            fbus_pkg::ST_SYNC: begin
                if (LINK.ci_ack) begin
                    next_r.st = fbus_pkg::ST_RUN;
                end
            end
            fbus_pkg::ST_RUN: begin
                next_r.retry = 1'b0;
            end
            fbus_pkg::ST_HALT: begin
                // Operator takes the interface address, both ends keep it
                if (fix && r.addr_fault) begin
                    next_r.bus_addr   = LINK.ci_addr;
                    next_r.save       = 1'b1;
                    next_r.wr         = 1'b1;
                    next_r.wr_addr    = LINK.ci_addr;
                    next_r.addr_fault = 1'b0;
                    next_r.st         = fbus_pkg::ST_SYNC;
                end else if (r.retry) begin
                    next_r.retry = 1'b0;
                    next_r.st    = fbus_pkg::ST_CHECK;
                end
            end
            default: begin
                next_r.st = fbus_pkg::ST_DETACH;
            end
        endcase

        // Losing the interface forces a full recheck on return
        if (!LINK.ci_present) begin
            next_r.st         = fbus_pkg::ST_DETACH;
            next_r.addr_fault = 1'b0;
            next_r.no_addr    = 1'b0;
        end

        // Register answer computed in the first access cycle
        if (access) begin
            next_r.slverr = 1'b0;
            next_r.rdata  = 32'h0000_0000;
            unique case (PADDR)
                fbus_pkg::REG_ADDR: begin
                    next_r.rdata  = {24'h00_0000, r.bus_addr};
                    next_r.slverr = PWRITE && r.lock;
                end
                fbus_pkg::REG_CONFIG: begin
                    next_r.rdata  = {28'h000_0000, r.retrofit,
                                     r.profile2, r.lock, r.check};
                end
                fbus_pkg::REG_CMD: begin
                    next_r.rdata  = 32'h0000_0000;
                end
                fbus_pkg::REG_STATUS: begin
                    next_r.rdata  = {8'h00, LINK.ci_addr, 7'h00,
                                     LINK.ci_bus_fault, LINK.ci_present,
                                     r.lock, r.no_addr, r.addr_fault,
                                     r.comm, r.st};
                end
                fbus_pkg::REG_PARAM: begin
                    next_r.rdata  = {14'h0000, r.react, 1'b0, r.monsel};
                    next_r.slverr = PWRITE && r.lock;
                end
                default: begin
                    next_r.slverr = 1'b1;
                end
            endcase
        end

        // Master-sent block parameters; refused while locked
        if (LINK.bp_valid && !r.lock) begin
            next_r.monsel = LINK.bp_data[14:0];
            next_r.react  = LINK.bp_data[fbus_pkg::PARAM_REACT +: 2];
        end

        // Software writes; placed last so a retry request beats its clear
        if (commit && PWRITE && !r.slverr) begin
            unique case (PADDR)
                fbus_pkg::REG_ADDR: begin
                    next_r.bus_addr = PWDATA[7:0];
                    next_r.retry    = 1'b1;
                end
                fbus_pkg::REG_CONFIG: begin
                    next_r.lock = PWDATA[fbus_pkg::CFG_LOCK];
                    if (!r.lock) begin
                        next_r.check    = PWDATA[fbus_pkg::CFG_CHECK];
                        // Sets the cyclic length and words sent across the link
                        next_r.profile2 = PWDATA[fbus_pkg::CFG_PROFILE];
                        next_r.retrofit = PWDATA[fbus_pkg::CFG_RETRO];
                    end
                end
                fbus_pkg::REG_CMD: begin
                    if (PWDATA[fbus_pkg::CMD_RECHECK]) begin
                        next_r.retry = 1'b1;
                    end
                end
                fbus_pkg::REG_PARAM: begin
                    next_r.monsel = PWDATA[14:0];
                    next_r.react  = PWDATA[fbus_pkg::PARAM_REACT +: 2];
                end
                default: begin
                    next_r.retry = next_r.retry;
                end
            endcase
        end

        // Run command from the master, overridden by bus fault reaction
        if (LINK.ci_bus_fault) begin
            unique case (r.react)
                fbus_pkg::REACT_KEEP: begin
                    next_r.motor = r.motor;
                end
                fbus_pkg::REACT_STOP: begin
                    next_r.motor = fbus_pkg::RUN_STOP;
                end
                fbus_pkg::REACT_FWD: begin
                    if (r.motor == fbus_pkg::RUN_STOP) begin
                        next_r.motor = fbus_pkg::RUN_FWD;
                    end
                end
                fbus_pkg::REACT_REV: begin
                    if (r.motor == fbus_pkg::RUN_STOP) begin
                        next_r.motor = fbus_pkg::RUN_REV;
                    end
                end
            endcase
        end else if (r.comm) begin
            next_r.motor = LINK.ci_cmd;
        end

        // Cyclic exchange only while agreed
        next_r.comm    = next_r.st == fbus_pkg::ST_RUN;
        next_r.cyc     = mon_word;
        next_r.cyc_len = r.comm ? mon_len : 3'h0;
    end

    // State register
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= CTL_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign PRDATA        = r.rdata;
    assign PREADY        = r.ready;
    assign PSLVERR       = r.slverr;
    assign MOTOR_RUN     = r.motor;
    assign COMM_ACTIVE   = r.comm;
    assign ADDR_FAULT    = r.addr_fault;
    assign LOCK_IND      = r.lock;
    assign ADDR_SAVE     = r.save;
    assign SAVED_ADDR    = r.bus_addr;
    assign LINK.ctl_addr = r.wr_addr;
    assign LINK.ctl_wr   = r.wr;
    assign LINK.comm_en  = r.comm;
    assign LINK.cyc_word = r.cyc;
    assign LINK.cyc_len  = r.cyc_len;
endmodule : fbus_ctl_end
`default_nettype wire

// ===== sim/fbus_link_chk.sv
// Checks on the link between the controller end and the interface end
`timescale 1ns/1ps
`default_nettype none
module fbus_link_chk (
    input wire logic             SYS_CLK,
    input wire logic             ARST_N,
    input wire logic             ci_present,
    input wire logic [7:0]       ci_addr,
    input wire logic             ci_ack,
    input wire logic [7:0]       ctl_addr,
    input wire logic             ctl_wr,
    input wire logic             comm_en,
    input wire logic [4:0][15:0] cyc_word,
    input wire logic [2:0]       cyc_len
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    // Address writes are single pulses answered one cycle later
    chk_wr_acked: assert property (ctl_wr |=> ci_ack && !ctl_wr)
        else $error("link write not acknowledged");
    chk_ack_cause: assert property (ci_ack |-> $past(ctl_wr))
        else $error("acknowledge without a write");
    // 2..64 is legal on every network type, so it must always be kept
    chk_addr_kept: assert property (ctl_wr && ctl_addr inside
        {[8'h02:8'h40]} |=> ci_addr == $past(ctl_addr))
        else $error("interface did not store the sent address");
    chk_addr_steady: assert property (ci_present && !ci_ack
        |-> $stable(ci_addr))
        else $error("interface address moved without a write");
    chk_comm_addr: assert property (comm_en |-> ci_addr != 8'hFF)
        else $error("bus running without an address");
    chk_detach_off: assert property ($fell(ci_present)
        |-> ##[1:3] !comm_en)
        else $error("bus still up after detach");
    chk_len_legal: assert property (cyc_len inside {3'h0, 3'h2, 3'h5})
        else $error("illegal cyclic length");
    chk_short_zero: assert property (cyc_len == 3'h2
        |-> cyc_word[4:2] == '0)
        else $error("words beyond reduced length not zero");
    cover property ($rose(comm_en));
    cover property (ctl_wr);
    cover property (cyc_len == 3'h2);
endmodule : fbus_link_chk
`default_nettype wire

// ===== sim/fieldbus_address_check_logic_test.sv
// Bench joining the controller end and the interface end
`timescale 1ns/1ps
`default_nettype none
module fieldbus_address_check_logic_test;
    logic             SYS_CLK, ARST_N, PSEL, PENABLE, PWRITE, er;
    logic [7:0]       PADDR, NV_ADDR, SAVED_ADDR, NV_WDATA;
    logic [31:0]      PWDATA, PRDATA, BP_IN_DATA, rd;
    logic             PREADY, PSLVERR, ATTACHED, IGNORE_BP, BP_IN_VALID;
    logic             BUS_FAULT, COMM_ACTIVE, ADDR_FAULT, LOCK_IND;
    logic             ADDR_SAVE, NV_WR, BUS_UP;
    logic [1:0]       NET_TYPE, CMD_RUN, MOTOR_RUN;
    logic [7:0][15:0] MON_SRC;
    logic [4:0][15:0] CYC_WORD;
    logic [2:0]       CYC_LEN;
    logic [1:0]       exp_run [8] = '{2'h0, 2'h0, 2'h1, 2'h2,
                                      2'h2, 2'h0, 2'h2, 2'h2};
    int               bad_count, checked, cycles, saves, nv_writes;
    fbus_link_if u_link ();
    fbus_ctl_end u_fbus_ctl_end (.SYS_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE,
        .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .MON_SRC, .LINK(u_link),
        .MOTOR_RUN, .COMM_ACTIVE, .ADDR_FAULT, .LOCK_IND, .ADDR_SAVE,
        .SAVED_ADDR);
    fbus_ci_end u_fbus_ci_end (.SYS_CLK, .ARST_N, .ATTACHED, .NET_TYPE,
        .NV_ADDR, .IGNORE_BP, .BP_IN_VALID, .BP_IN_DATA, .BUS_FAULT, .CMD_RUN,
        .LINK(u_link), .NV_WR, .NV_WDATA, .BUS_UP, .CYC_WORD, .CYC_LEN);
    fbus_link_chk u_fbus_link_chk (.SYS_CLK, .ARST_N,
        .ci_present(u_link.ci_present), .ci_addr(u_link.ci_addr),
        .ci_ack(u_link.ci_ack), .ctl_addr(u_link.ctl_addr),
        .ctl_wr(u_link.ctl_wr), .comm_en(u_link.comm_en),
        .cyc_word(u_link.cyc_word), .cyc_len(u_link.cyc_len));
    // 40 MHz system clock
    initial begin
        SYS_CLK = 1'h0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    // Hang guard: the whole run needs a few hundred cycles at most
    // Store pulses are counted here, as a one-cycle pulse is easily missed
    always @(posedge SYS_CLK) begin
        cycles++;
        if (ADDR_SAVE === 1'h1) saves++;
        if (NV_WR === 1'h1) nv_writes++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; request held until PREADY is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        do @(posedge SYS_CLK); while (PREADY !== 1'h1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask : apb
    // Wait for comm (f=0) or address fault (f=1) to reach v
    task automatic wt(input logic f, input logic v);
        do @(posedge SYS_CLK); while ((f ? ADDR_FAULT : COMM_ACTIVE) !== v);
    endtask : wt
    task automatic replug();
        ATTACHED <= 1'h0;
        repeat (8) @(posedge SYS_CLK);
        ATTACHED <= 1'h1;
    endtask : replug
    task automatic bp(input logic [31:0] d);
        BP_IN_DATA <= d;
        BP_IN_VALID <= 1'h1;
        @(posedge SYS_CLK);
        BP_IN_VALID <= 1'h0;
        repeat (4) @(posedge SYS_CLK);
    endtask : bp
    task automatic finish_test();
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // Main sequence: agreement cases, settings, then fault reactions
    initial begin
        {PSEL, PENABLE, PWRITE, IGNORE_BP, BP_IN_VALID, BUS_FAULT} = '0;
        {PADDR, PWDATA, BP_IN_DATA, NET_TYPE, CMD_RUN} = '0;
        {ARST_N, ATTACHED, NV_ADDR} = 10'h1FF;
        for (int i = 0; i < 8; i++) MON_SRC[i] = 16'hA000 + 16'(i);
        repeat (10) @(posedge SYS_CLK);
        ARST_N <= 1'h1;
        repeat (20) @(posedge SYS_CLK);
        chk(COMM_ACTIVE, 32'h0);
        apb(1'h1, 8'h00, 32'h10);
        wt(1'h0, 1'h1);
        chk(NV_WDATA, 32'h10);
        apb(1'h0, 8'h14, 32'h0);
        chk(er, 32'h1);
        apb(1'h1, 8'h00, 32'hFF);
        replug();
        wt(1'h0, 1'h1);
        chk(SAVED_ADDR, 32'h10);
        apb(1'h1, 8'h00, 32'h30);
        replug();
        wt(1'h0, 1'h1);
        chk(NV_WDATA, 32'h30);
        apb(1'h1, 8'h04, 32'h1);
        apb(1'h1, 8'h00, 32'h20);
        replug();
        wt(1'h1, 1'h1);
        chk(COMM_ACTIVE, 32'h0);
        apb(1'h1, 8'h08, 32'h1);
        wt(1'h0, 1'h1);
        chk(SAVED_ADDR, 32'h30);
        // Cyclic words trail the run state by two registers
        repeat (4) @(posedge SYS_CLK);
        chk(BUS_UP, 32'h1);
        chk(CYC_LEN, 32'h5);
        chk(CYC_WORD[0], 32'hA000);
        replug();
        wt(1'h0, 1'h1);
        chk(NV_WDATA, 32'h30);
        apb(1'h1, 8'h04, 32'h5);
        repeat (4) @(posedge SYS_CLK);
        chk(CYC_LEN, 32'h2);
        chk(CYC_WORD[2], 32'h0);
        IGNORE_BP <= 1'h1;
        bp(32'h3);
        apb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h4688);
        IGNORE_BP <= 1'h0;
        bp(32'h3);
        apb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h3);
        apb(1'h1, 8'h04, 32'h9);
        repeat (4) @(posedge SYS_CLK);
        chk(CYC_WORD[0], 32'hA000);
        apb(1'h1, 8'h04, 32'h2);
        apb(1'h1, 8'h10, 32'h5);
        chk(er, 32'h1);
        chk(LOCK_IND, 32'h1);
        bp(32'h5);
        apb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h3);
        apb(1'h1, 8'h04, 32'h0);
        // Each reaction with the motor stopped, then running reverse
        for (int i = 0; i < 8; i++) begin
            BUS_FAULT <= 1'h0;
            CMD_RUN <= (i >= 4) ? fbus_pkg::RUN_REV : fbus_pkg::RUN_STOP;
            apb(1'h1, 8'h10, {14'h0, i[1:0], 16'h0});
            repeat (8) @(posedge SYS_CLK);
            BUS_FAULT <= 1'h1;
            repeat (8) @(posedge SYS_CLK);
            chk(MOTOR_RUN, exp_run[i]);
        end
        // Two controller saves, three interface stores, none when equal
        chk(saves, 32'h2);
        chk(nv_writes, 32'h3);
        finish_test();
    end
endmodule : fieldbus_address_check_logic_test
`default_nettype wire
